// *** rtl/mlb_pkg.sv ***
// shared constants and types for the multiplexed local bus master
package mlb_pkg;
  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int MLB_DATA_W = 32;
  localparam int MLB_BE_W = 4;
  localparam int MLB_WORD_W = MLB_DATA_W + MLB_BE_W;
  localparam int MLB_ADDR_W = 30;
  localparam int MLB_FIFO_DEPTH = 4;
  localparam int MLB_CNT_W = 3;
  // ----------------------------------------------------------------
  // burst length codes carried on the low address lines
  // ----------------------------------------------------------------
  localparam logic [1:0] MLB_SIZE_1W = 2'h0;
  localparam logic [1:0] MLB_SIZE_2W = 2'h1;
  localparam logic [1:0] MLB_SIZE_3W = 2'h2;
  localparam logic [1:0] MLB_SIZE_4W = 2'h3;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MLB_SIZE_LSB = 0;
  localparam int MLB_ADDR_LSB = 2;
  localparam logic [MLB_BE_W-1:0] MLB_BE_ALL = 4'hf;
  localparam logic [MLB_DATA_W-1:0] MLB_DATA_RESET = 32'h0;
  localparam logic [MLB_WORD_W-1:0] MLB_WORD_RESET = 36'h0;
  localparam logic [MLB_ADDR_W-1:0] MLB_ADDR_RESET = 30'h0;
  localparam logic MLB_PHASE_RESET = 1'b0;
  localparam logic MLB_PHASE_LAST = 1'b1;
  localparam logic [MLB_CNT_W-1:0] MLB_CNT_ONE = 3'h1;
  // ----------------------------------------------------------------
  // bus states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    MLB_S_IDLE = 6'h01,
    MLB_S_ADDR = 6'h02,
    MLB_S_DATA = 6'h04,
    MLB_S_WAIT = 6'h08,
    MLB_S_RECOV = 6'h10,
    MLB_S_LOCKW = 6'h20
  } mlb_state_t;
  // ----------------------------------------------------------------
  // byte lane check: one lane, aligned pair, or all four
  // ----------------------------------------------------------------
  function automatic logic [MLB_BE_W-1:0] mlb_be_fix(input logic [MLB_BE_W-1:0] be);
    logic ok;
    ok = (be == 4'h1) || (be == 4'h2) || (be == 4'h4) || (be == 4'h8) ||
         (be == 4'h3) || (be == 4'hc) || (be == 4'hf);
    return ok ? be : MLB_BE_ALL;
  endfunction : mlb_be_fix
endpackage : mlb_pkg

// *** rtl/mlb_master.sv ***
// multiplexed local bus master with its write-word fifo
`timescale 1ns/1ps
// Notes on behaviour
// (R01) bus state lasts two input clocks
// (R02) address state: word address plus size
// (R03) data state: all lines carry data
// (R04) address/data lines float when unused
// (R05) size code: 00 one to 11 four
// (R06) latch strobe low only in address state
// (R07) latch strobe floats idle and after access
// (R08) address strobe in address state, not in first data state
// (R09) address strobe again after each ready but the last
// (R10) write/read latched through data states
// (R11) direction low reads, high writes
// (R12) direction never changes while data enabled
// (R13) data enable through data and wait
// (R14) agent asserts ready when data valid
// (R15) no ready means wait, no strobe
// (R16) lock keeps other masters off bus
// (R17) locked read waits, then asserts lock
// (R18) locked write releases lock in address
// (R19) byte enables lead data by one word
// (R20) legal byte enables, held during waits
// (R21) recovery state after last word

// ------------------------------------------------------------------
// fifo
// ------------------------------------------------------------------
module mlb_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  output logic [WIDTH-1:0] out_peek,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic in_ready_reg;
  wire push = in_valid && in_ready_reg;
  wire pop = out_ready && (count_reg != '0);
  wire [PW:0] count_next = count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  wire [PW-1:0] rd_ptr_inc = rd_ptr_reg + {{(PW-1){1'b0}}, 1'b1};

  assign in_ready = in_ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign out_peek = mem[rd_ptr_inc];
  assign count = count_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // ready is registered so back-pressure never depends on a comb path
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= push ? wr_ptr_reg + {{(PW-1){1'b0}}, 1'b1} : wr_ptr_reg;
      rd_ptr_reg <= pop ? rd_ptr_inc : rd_ptr_reg;
      count_reg <= count_next;
      in_ready_reg <= (count_next != DEPTH[PW:0]);
    end
  end
endmodule : mlb_fifo

// ------------------------------------------------------------------
// bus master
// ------------------------------------------------------------------
module mlb_master (
  // ref_clk is the double-rate bus clock input
  input wire logic ref_clk,
  input wire logic reset_n,
  // command
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_rmw,
  input wire logic [mlb_pkg::MLB_ADDR_W-1:0] cmd_addr,
  input wire logic [1:0] cmd_size,
  output logic cmd_accept,
  // word stream: byte enables and write data, one entry per word
  input wire logic wdat_valid,
  input wire logic [mlb_pkg::MLB_BE_W-1:0] wdat_be,
  input wire logic [mlb_pkg::MLB_DATA_W-1:0] wdat_data,
  output logic wdat_ready,
  // read data
  output logic rdat_valid,
  output logic [mlb_pkg::MLB_DATA_W-1:0] rdat_data,
  // multiplexed lines
  input wire logic [mlb_pkg::MLB_DATA_W-1:0] mux_addr_data_lines_in,
  output logic [mlb_pkg::MLB_DATA_W-1:0] mux_addr_data_lines_out,
  output logic mux_addr_data_lines_oe,
  // strobes and qualifiers
  output logic ale_n,
  output logic ale_oe,
  output logic addr_state_strobe_n,
  output logic write_read,
  output logic xfer_direction,
  output logic data_window_enable_n,
  output logic [mlb_pkg::MLB_BE_W-1:0] byte_lane_enable_n,
  input wire logic ready_n,
  // bus lock, open drain
  input wire logic lock_in_n,
  output logic lock_out_n,
  output logic lock_oe
);
  import mlb_pkg::*;

  mlb_state_t state_reg;
  mlb_state_t state_next;
  logic phase_reg;
  logic ready_n_s1, ready_n_s2, lock_n_s1, lock_n_s2;
  logic [MLB_DATA_W-1:0] lad_s1, lad_s2;
  logic wr_reg, rmw_reg, lock_hold_reg;
  logic [MLB_ADDR_W-1:0] addr_reg;
  logic [1:0] size_reg, left_reg;
  logic [MLB_WORD_W-1:0] word_reg;
  logic [MLB_WORD_W-1:0] head_word, peek_word;
  logic [MLB_CNT_W-1:0] fifo_count;
  logic head_valid;
  logic ad_oe_reg, ale_n_reg, ale_oe_reg, ads_n_reg, dt_reg, den_n_reg;
  logic lock_n_reg, accept_reg, rdv_reg;
  logic [MLB_DATA_W-1:0] ad_reg, rdd_reg;
  logic [MLB_BE_W-1:0] be_n_reg;

  // ----------------------------------------------------------------
  // clock division and pin synchronisers
  // ----------------------------------------------------------------
  wire tick = (phase_reg == MLB_PHASE_LAST); // R01
  wire in_idle = (state_reg == MLB_S_IDLE);
  wire in_xfer = (state_reg == MLB_S_DATA) || (state_reg == MLB_S_WAIT);
  wire [MLB_CNT_W-1:0] need = {1'b0, cmd_size} + MLB_CNT_ONE;
  // waiting for every word up front keeps a burst from starving mid-way
  wire start = tick && in_idle && cmd_valid && head_valid && (fifo_count >= need);
  wire cur_write = in_idle ? cmd_write : wr_reg;
  wire cur_rmw = in_idle ? cmd_rmw : rmw_reg;
  wire [MLB_ADDR_W-1:0] cur_addr = in_idle ? cmd_addr : addr_reg;
  wire [1:0] cur_size = in_idle ? cmd_size : size_reg;
  wire lock_busy = !lock_n_s2 && !lock_hold_reg;
  wire rmw_rd_block = cur_rmw && !cur_write && lock_busy; // R17
  wire go_addr = (start || (tick && (state_reg == MLB_S_LOCKW))) && !rmw_rd_block;
  wire word_done = tick && in_xfer && !ready_n_s2; // R15
  wire more = (left_reg != 2'h0);
  wire pop = go_addr || (word_done && more);

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MLB_S_IDLE: begin
        if (start) begin
          state_next = go_addr ? MLB_S_ADDR : MLB_S_LOCKW;
        end
      end
      MLB_S_LOCKW: begin
        if (go_addr) begin
          state_next = MLB_S_ADDR;
        end
      end
      MLB_S_ADDR: begin
        if (tick) begin
          state_next = MLB_S_DATA;
        end
      end
      MLB_S_DATA, MLB_S_WAIT: begin
        if (word_done) begin
          state_next = more ? MLB_S_DATA : MLB_S_RECOV; // R21
        end else if (tick) begin
          state_next = MLB_S_WAIT; // R15
        end
      end
      MLB_S_RECOV: begin
        if (tick) begin
          state_next = MLB_S_IDLE;
        end
      end
      default: begin
        state_next = MLB_S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next values of the pins, aligned with the state they belong to
  // ----------------------------------------------------------------
  wire n_addr = (state_next == MLB_S_ADDR);
  wire n_xfer = (state_next == MLB_S_DATA) || (state_next == MLB_S_WAIT);
  wire [MLB_WORD_W-1:0] word_next = pop ? head_word : word_reg;
  // an empty slot shows all lanes, never a stale or unknown value
  wire peek_ok = (fifo_count > MLB_CNT_ONE);
  wire [MLB_BE_W-1:0] peek_be = peek_ok ? peek_word[MLB_WORD_W-1 -: MLB_BE_W] : MLB_BE_ALL;
  wire [MLB_BE_W-1:0] head_be = head_valid ? head_word[MLB_WORD_W-1 -: MLB_BE_W] : MLB_BE_ALL;
  wire [MLB_BE_W-1:0] be_src = word_done && more ? peek_be : head_be;
  wire [MLB_BE_W-1:0] be_sel = n_addr ? word_next[MLB_WORD_W-1 -: MLB_BE_W] : be_src;
  // leaving the address state the enables step on to the second word
  wire be_step = n_addr || word_done || (tick && (state_reg == MLB_S_ADDR));
  wire [MLB_BE_W-1:0] be_hold = be_step ? be_sel : ~be_n_reg;
  wire [MLB_DATA_W-1:0] ad_next = n_addr ? {cur_addr, cur_size} : word_next[MLB_DATA_W-1:0];
  wire ad_oe_next = n_addr || (n_xfer && wr_reg);
  // the strobe stands for the whole bus state, as every other pin does
  wire ads_n_next = tick ? !(n_addr || ((state_next == MLB_S_DATA) && word_done)) : ads_n_reg;
  wire dt_next = go_addr ? cur_write : dt_reg;
  wire lock_next = go_addr ? (cur_rmw ? !cur_write : lock_hold_reg) : lock_hold_reg;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      phase_reg <= MLB_PHASE_RESET;
      state_reg <= MLB_S_IDLE;
      ready_n_s1 <= 1'b1;
      ready_n_s2 <= 1'b1;
      lock_n_s1 <= 1'b1;
      lock_n_s2 <= 1'b1;
      lad_s1 <= MLB_DATA_RESET;
      lad_s2 <= MLB_DATA_RESET;
    end else begin
      phase_reg <= ~phase_reg; // R01
      state_reg <= state_next;
      ready_n_s1 <= ready_n;
      ready_n_s2 <= ready_n_s1;
      lock_n_s1 <= lock_in_n;
      lock_n_s2 <= lock_n_s1;
      lad_s1 <= mux_addr_data_lines_in;
      lad_s2 <= lad_s1;
    end
  end

  // ----------------------------------------------------------------
  // latched access and the word being transferred
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_reg <= 1'b0;
      rmw_reg <= 1'b0;
      addr_reg <= MLB_ADDR_RESET;
      size_reg <= MLB_SIZE_1W;
      left_reg <= 2'h0;
      word_reg <= MLB_WORD_RESET;
      lock_hold_reg <= 1'b0;
    end else begin
      wr_reg <= start ? cmd_write : wr_reg; // R10
      rmw_reg <= start ? cmd_rmw : rmw_reg;
      addr_reg <= start ? cmd_addr : addr_reg;
      size_reg <= start ? cmd_size : size_reg;
      left_reg <= go_addr ? cur_size : (word_done && more ? left_reg - 2'h1 : left_reg);
      word_reg <= word_next;
      lock_hold_reg <= lock_next; // R17 R18
    end
  end

  // ----------------------------------------------------------------
  // pin registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ad_reg <= MLB_DATA_RESET;
      ad_oe_reg <= 1'b0;
      ale_n_reg <= 1'b1;
      ale_oe_reg <= 1'b0;
      ads_n_reg <= 1'b1;
      dt_reg <= 1'b0;
      den_n_reg <= 1'b1;
      be_n_reg <= ~MLB_BE_ALL;
      lock_n_reg <= 1'b1;
      accept_reg <= 1'b0;
      rdv_reg <= 1'b0;
      rdd_reg <= MLB_DATA_RESET;
    end else begin
      ad_reg <= ad_next; // R02 R03 R05
      ad_oe_reg <= ad_oe_next; // R04
      ale_n_reg <= !n_addr; // R06
      ale_oe_reg <= n_addr || n_xfer; // R07
      ads_n_reg <= ads_n_next; // R08 R09
      dt_reg <= dt_next; // R11 R12
      den_n_reg <= !n_xfer; // R13
      be_n_reg <= ~mlb_be_fix(be_hold); // R19 R20
      lock_n_reg <= !lock_next; // R16
      accept_reg <= start;
      rdv_reg <= word_done && !wr_reg;
      rdd_reg <= word_done && !wr_reg ? lad_s2 : rdd_reg;
    end
  end

  assign mux_addr_data_lines_out = ad_reg;
  assign mux_addr_data_lines_oe = ad_oe_reg;
  assign ale_n = ale_n_reg;
  assign ale_oe = ale_oe_reg;
  assign addr_state_strobe_n = ads_n_reg;
  assign write_read = dt_reg;
  assign xfer_direction = dt_reg;
  assign data_window_enable_n = den_n_reg;
  assign byte_lane_enable_n = be_n_reg;
  assign lock_out_n = lock_n_reg;
  assign lock_oe = lock_hold_reg;
  assign cmd_accept = accept_reg;
  assign rdat_valid = rdv_reg;
  assign rdat_data = rdd_reg;

  mlb_fifo #(
    .WIDTH(MLB_WORD_W),
    .DEPTH(MLB_FIFO_DEPTH)
  ) u_words (
    .clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(wdat_valid),
    .in_data({wdat_be, wdat_data}),
    .in_ready(wdat_ready),
    .out_valid(head_valid),
    .out_data(head_word),
    .out_peek(peek_word),
    .out_ready(pop),
    .count(fifo_count)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_phase_toggle: assert property ($past(reset_n) |-> phase_reg != $past(phase_reg)) // R01
    else $error("bus phase did not toggle");
  a_addr_size_out: assert property (!ale_n_reg |-> ad_oe_reg && ads_n_reg == 1'b0 // R02
    && ad_reg[1:0] == size_reg) else $error("address state without size code");
  a_lad_float: assert property (state_reg == MLB_S_IDLE |-> !ad_oe_reg) // R04
    else $error("lines driven while idle");
  a_ale_data_high: assert property (!den_n_reg |-> ale_n_reg && ale_oe_reg) // R06
    else $error("latch strobe low in data");
  a_ale_float_end: assert property ($rose(state_reg == MLB_S_RECOV) |-> !ale_oe_reg[*2]) // R07
    else $error("latch strobe driven after access");
  a_first_data_ads: assert property ($fell(den_n_reg) |-> ads_n_reg) // R08
    else $error("address strobe in first data state");
  a_ads_after_ready: assert property (word_done && more |=> !ads_n_reg ##1 !ads_n_reg) // R09
    else $error("no address strobe after ready");
  a_wait_no_ads: assert property (state_reg == MLB_S_WAIT |-> ads_n_reg) // R15
    else $error("address strobe in wait state");
  a_dir_stable: assert property (!den_n_reg && $past(!den_n_reg) |-> $stable(dt_reg)) // R12
    else $error("direction changed with data enabled");
  a_den_window: assert property (in_xfer |-> !den_n_reg && dt_reg == wr_reg) // R13
    else $error("data enable missing in transfer");
  a_be_hold_wait: assert property (state_reg == MLB_S_WAIT |-> $stable(be_n_reg)) // R20
    else $error("byte enables moved in wait");
  a_lock_read: assert property (go_addr && cur_rmw && !cur_write |=> !lock_n_reg) // R17
    else $error("locked read did not assert lock");
endmodule : mlb_master

// *** tb/mlb_agent.sv ***
// far-side memory agent for the multiplexed local bus master
`timescale 1ns/1ps
module mlb_agent (
  // clock
  input wire logic clk,
  // lines from the master
  input wire logic [31:0] lines_out,
  input wire logic lines_oe,
  input wire logic ale_n,
  input wire logic ale_oe,
  input wire logic ads_n,
  input wire logic dir,
  input wire logic den_n,
  input wire logic [3:0] be_n,
  input wire logic lock_out_n,
  input wire logic lock_oe,
  // lines to the master
  output logic [31:0] lines_in,
  output logic ready_n,
  output logic lock_in_n,
  // test controls
  input wire logic [2:0] stall,
  input wire logic ext_lock,
  // observed address and write words
  output logic obs_valid,
  output logic [36:0] obs_word
);
  logic ale_q = 1'b1;
  logic ads_odd = 1'b0;
  logic den_q = 1'b1;
  logic w_reg = 1'b0;
  logic [29:0] a_reg = 30'h0;
  logic [1:0] idx = 2'h0;
  logic [2:0] cnt = 3'h0;
  logic [31:0] d_q = 32'h0;
  logic [31:0] last = 32'h0;
  // a word starts on the first cycle of each two-cycle strobe; strobes may run back to back
  wire ads_fall = !ads_n && !ads_odd;
  wire [1:0] idx_now = idx + {1'b0, ads_fall && !den_n};
  wire [2:0] cnt_now = ads_fall ? 3'h0 : cnt;
  wire drv = !den_n && !lines_oe;
  // the master sees ready a bus state late, so it is offered for two cycles per word only
  assign ready_n = !(!den_n && (cnt_now == stall || cnt_now == stall + 3'h1));
  assign lock_in_n = !((lock_oe && !lock_out_n) || ext_lock);
  // a released bus never shows its last value
  assign lines_in = lines_oe ? lines_out : (drv ? ~{a_reg, idx_now} : ~last);
  initial obs_valid = 1'b0;
  always @(posedge clk) begin
    ale_q <= ale_n || !ale_oe;
    ads_odd <= ads_fall;
    den_q <= den_n;
    d_q <= lines_out;
    last <= lines_in;
    cnt <= den_n ? 3'h0 : (ads_fall ? 3'h1 : (cnt == 3'h7 ? cnt : cnt + 3'h1));
    idx <= (!ale_n && ale_oe) ? 2'h0 : idx_now;
    obs_valid <= 1'b0;
    if (!ale_n && ale_oe && ale_q) begin
      a_reg <= lines_out[31:2];
      w_reg <= dir;
      obs_valid <= 1'b1;
      obs_word <= {dir, be_n, lines_out};
    end else if (w_reg && !den_q && (den_n || ads_fall)) begin
      obs_valid <= 1'b1;
      obs_word <= {1'b1, 4'h0, d_q};
    end
  end
endmodule : mlb_agent

// *** tb/muxed_local_bus_master_test.sv ***
// self-checking bench for the multiplexed local bus master
`timescale 1ns/1ps
module muxed_local_bus_master_test;
  import mlb_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_rmw = 1'b0;
  logic [MLB_ADDR_W-1:0] cmd_addr = 30'h0;
  logic [1:0] cmd_size = 2'h0;
  logic wdat_valid = 1'b0;
  logic [MLB_BE_W-1:0] wdat_be = 4'h0;
  logic [MLB_DATA_W-1:0] wdat_data = 32'h0;
  logic [2:0] stall = 3'h0;
  logic ext_lock = 1'b0;
  logic last_w = 1'b0;
  logic cmd_accept, wdat_ready, rdat_valid, mux_oe, ale_n, ale_oe, ads_n, write_read;
  logic dir, den_n, lock_out_n, lock_oe, lock_in_n, ready_n, obs_valid;
  logic [31:0] rdat_data, mux_out, mux_in, d;
  logic [3:0] be_n;
  logic [36:0] obs_word;
  logic [36:0] exp_q[$];
  logic [3:0] be_tab[9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf, 4'h5, 4'h6};
  logic [31:0] rng = 32'd73;
  int failures = 0;
  int check_count = 0;
  always #5 ref_clk = ~ref_clk;
  mlb_master dut (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_rmw(cmd_rmw), .cmd_addr(cmd_addr), .cmd_size(cmd_size),
    .cmd_accept(cmd_accept), .wdat_valid(wdat_valid), .wdat_be(wdat_be),
    .wdat_data(wdat_data), .wdat_ready(wdat_ready), .rdat_valid(rdat_valid),
    .rdat_data(rdat_data), .mux_addr_data_lines_in(mux_in),
    .mux_addr_data_lines_out(mux_out), .mux_addr_data_lines_oe(mux_oe), .ale_n(ale_n),
    .ale_oe(ale_oe), .addr_state_strobe_n(ads_n), .write_read(write_read),
    .xfer_direction(dir), .data_window_enable_n(den_n), .byte_lane_enable_n(be_n),
    .ready_n(ready_n), .lock_in_n(lock_in_n), .lock_out_n(lock_out_n), .lock_oe(lock_oe));
  mlb_agent agent (.clk(ref_clk), .lines_out(mux_out), .lines_oe(mux_oe), .ale_n(ale_n),
    .ale_oe(ale_oe), .ads_n(ads_n), .dir(dir), .den_n(den_n), .be_n(be_n),
    .lock_out_n(lock_out_n), .lock_oe(lock_oe), .lines_in(mux_in), .ready_n(ready_n),
    .lock_in_n(lock_in_n), .stall(stall), .ext_lock(ext_lock), .obs_valid(obs_valid),
    .obs_word(obs_word));
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd
  task automatic chk(input string what, input logic [36:0] seen, input logic [36:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  // ------------------------------------------------------------------
  // bus transfer: queue the words, then hand over the command
  // ------------------------------------------------------------------
  task automatic xfer(input logic w, input logic read_modify_write, input logic [1:0] sz, input int bi);
    logic [29:0] a;
    logic quiet;
    int n;
    d = rnd();
    a = d[29:0];
    quiet = (exp_q.size() == 0);
    exp_q.push_back({w, bi < 7 ? ~be_tab[bi] : 4'h0, a, sz});
    for (int i = 0; i <= int'(sz); i++) begin
      d = rnd();
      wdat_be = (i == 0) ? be_tab[bi] : 4'hf;
      wdat_data = d;
      wdat_valid = 1'b1;
      n = 0;
      while (wdat_ready !== 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      chk("wdat_ready", {36'h0, wdat_ready}, 37'h1);
      cyc(1);
      exp_q.push_back(w ? {1'b1, 4'h0, d} : {5'h0, ~{a, 2'(i)}});
    end
    wdat_valid = 1'b0;
    if (quiet && sz == 2'h3) begin
      cyc(2);
      chk("wdat_ready full", {36'h0, wdat_ready}, 37'h0);
    end
    last_w = w;
    cmd_write = w;
    cmd_rmw = read_modify_write;
    cmd_addr = a;
    cmd_size = sz;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_accept !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk("cmd_accept", {36'h0, cmd_accept}, 37'h1);
    cmd_valid = 1'b0;
  endtask : xfer
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 600) begin
      cyc(1);
      n++;
    end
    cyc(8);
    chk("queue left", 37'(exp_q.size()), 37'h0);
    chk("idle lines oe", {36'h0, mux_oe}, 37'h0);
    chk("idle latch oe", {36'h0, ale_oe}, 37'h0);
    chk("idle data enable", {36'h0, den_n}, 37'h1);
    chk("write_read held", {36'h0, write_read}, {36'h0, last_w});
  endtask : drain
  // ------------------------------------------------------------------
  // watcher: every address, write word and read word in issue order
  // ------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (obs_valid === 1'b1 || rdat_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("stray word", 37'h1, 37'h0);
      end else begin
        chk("bus word", obs_valid === 1'b1 ? obs_word : {5'h0, rdat_data}, exp_q.pop_front());
      end
    end
  end
  initial begin
    #300us;
    failures++;
    give_verdict();
  end
  initial begin
    cyc(2);
    reset_n = 1'b1;
    cyc(2);
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, 1'b0, 2'(s), s);
      xfer(1'b0, 1'b0, 2'(s), s + 4);
    end
    drain();
    $display("test burst codes done");
    // slow agent: wait states on every word, random mix
    stall = 3'h5;
    for (int k = 0; k < 6; k++) begin
      d = rnd();
      xfer(d[4], 1'b0, d[1:0], int'(d[11:8]) % 9);
    end
    drain();
    $display("test wait states done");
    // fifo filled until it refuses, then a four-word write drains it
    stall = 3'h2;
    xfer(1'b1, 1'b0, 2'h3, 6);
    drain();
    $display("test fifo full done");
    // locked read must wait for a foreign lock, then hold its own
    stall = 3'h0;
    ext_lock = 1'b1;
    // let the foreign lock pass the master's synchroniser before the command
    cyc(4);
    xfer(1'b0, 1'b1, 2'h0, 6);
    cyc(20);
    chk("blocked latch oe", {36'h0, ale_oe}, 37'h0);
    chk("blocked queue", 37'(exp_q.size()), 37'h2);
    ext_lock = 1'b0;
    drain();
    chk("lock held", {35'h0, lock_oe, lock_out_n}, 37'h2);
    xfer(1'b1, 1'b1, 2'h1, 6);
    drain();
    chk("lock dropped", {36'h0, lock_oe}, 37'h0);
    $display("test bus lock done");
    give_verdict();
  end
endmodule : muxed_local_bus_master_test
